// ==== rtl/mfp_top.v ====
// Dual-channel modem pin and multi-function output block with an APB slave.
// Assumes transmitter, receive FIFO and flow logic on pclk feed the level inputs.
//
// What this block does
// - Each channel drives an active-low receive-ready output from its receive FIFO status.
// - With auto CTS enabled, the CTS input gates transmission and its enable bit gates the flag.
// - DSR, CD and RI are readable status only and change no channel behaviour.
// - RTS and DTR are active-low outputs driven from the modem control word.
// - The multi-function pin carries exactly one of three functions chosen by a two-bit field.
// - With user output two selected the pin is low when modem control bit 3 is one.
// - Modem control bit 3 resets to one, so the multi-function pin starts low.
// - With the baud function selected the pin carries the 16x baud clock.
// - With receive-ready selected the pin matches the dedicated receive-ready output.
// - During reset the transmit outputs sit high and the receive inputs are ignored.
`timescale 1ns/100ps
`include "mfp_consts.vh"

module mfp_top
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        tx_data_a,
	input  wire        tx_data_b,
	input  wire        rx_fifo_ready_a,
	input  wire        rx_fifo_ready_b,
	input  wire        rts_hold_a,
	input  wire        rts_hold_b,
	input  wire        serial_in_a,
	input  wire        serial_in_b,
	input  wire        cts_n_a,
	input  wire        cts_n_b,
	input  wire        dsr_n_a,
	input  wire        dsr_n_b,
	input  wire        cd_n_a,
	input  wire        cd_n_b,
	input  wire        ri_n_a,
	input  wire        ri_n_b,
	output wire        serial_out_a,
	output wire        serial_out_b,
	output wire        rx_data_a,
	output wire        rx_data_b,
	output wire        rts_n_a,
	output wire        rts_n_b,
	output wire        dtr_n_a,
	output wire        dtr_n_b,
	output wire        multi_function_out_a,
	output wire        multi_function_out_b,
	output wire        receive_ready_out_a,
	output wire        receive_ready_out_b,
	output wire        tx_allow_a,
	output wire        tx_allow_b,
	output wire        cts_flow_irq_a,
	output wire        cts_flow_irq_b,
	output wire        rts_flow_irq_a,
	output wire        rts_flow_irq_b
);

	// ****************************************************************
	// Register file
	// ****************************************************************
	reg  [7:0]  mcr_a_r;
	reg  [7:0]  mcr_b_r;
	reg  [7:0]  efr_a_r;
	reg  [7:0]  efr_b_r;
	reg  [7:0]  ier_a_r;
	reg  [7:0]  ier_b_r;
	reg  [7:0]  afr_a_r;
	reg  [7:0]  afr_b_r;
	reg  [15:0] div_a_r;
	reg  [15:0] div_b_r;
	wire [3:0]  modem_stat_a;
	wire [3:0]  modem_stat_b;
	wire        access;
	wire        wr;
	wire        chan_a;
	wire [5:0]  ofs;
	reg  [31:0] rdata_nxt;
	reg         known_nxt;

	// Offset inside the selected channel window
	function [5:0] ch_ofs;
		input [31:0] addr;
		begin
			ch_ofs = {1'b0, addr[4:0]};
		end
	endfunction

	// True when the address lies in the decoded block and is word aligned
	function in_block;
		input [31:0] addr;
		begin
			in_block = (addr[31:`MFP_ADDR_HI-1] == 26'h0000000) && (addr[1:0] == 2'h0);
		end
	endfunction

	assign access = psel & penable;
	assign wr     = access & pwrite & in_block(paddr);
	assign chan_a = paddr[`MFP_CHANNEL_SELECT_BIT];
	assign ofs    = ch_ofs(paddr);

	// Software writes land only in the access phase, zero wait states
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mcr_a_r <= `MFP_RST_MCR;
			mcr_b_r <= `MFP_RST_MCR;
			efr_a_r <= `MFP_RST_EFR;
			efr_b_r <= `MFP_RST_EFR;
			ier_a_r <= `MFP_RST_IER;
			ier_b_r <= `MFP_RST_IER;
			afr_a_r <= `MFP_RST_AFR;
			afr_b_r <= `MFP_RST_AFR;
			div_a_r <= `MFP_RST_DIV;
			div_b_r <= `MFP_RST_DIV;
		end
		else if (wr)
		begin
			if (chan_a)
			begin
				if (ofs == `MFP_OFS_MCR)
					mcr_a_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_EFR)
					efr_a_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_IER)
					ier_a_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_AFR)
					afr_a_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_DIV)
					div_a_r <= pwdata[15:0];
			end
			else
			begin
				if (ofs == `MFP_OFS_MCR)
					mcr_b_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_EFR)
					efr_b_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_IER)
					ier_b_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_AFR)
					afr_b_r <= pwdata[7:0];
				if (ofs == `MFP_OFS_DIV)
					div_b_r <= pwdata[15:0];
			end
		end
	end

	// ****************************************************************
	// Read mux and decode
	// ****************************************************************
	// Status word: modem lines asserted high, then receive ready, then tx allow
	always @*
	begin
		rdata_nxt = 32'h00000000;
		known_nxt = in_block(paddr);
		case (ofs)
			`MFP_OFS_MCR:  rdata_nxt = {24'h000000, chan_a ? mcr_a_r : mcr_b_r};
			`MFP_OFS_EFR:  rdata_nxt = {24'h000000, chan_a ? efr_a_r : efr_b_r};
			`MFP_OFS_IER:  rdata_nxt = {24'h000000, chan_a ? ier_a_r : ier_b_r};
			`MFP_OFS_AFR:  rdata_nxt = {24'h000000, chan_a ? afr_a_r : afr_b_r};
			`MFP_OFS_DIV:  rdata_nxt = {16'h0000, chan_a ? div_a_r : div_b_r};
			`MFP_OFS_STAT: rdata_nxt = chan_a
				? {26'h0000000, tx_allow_a, ~receive_ready_out_a, modem_stat_a}
				: {26'h0000000, tx_allow_b, ~receive_ready_out_b, modem_stat_b};
			default:       known_nxt = 1'b0;
		endcase
		if (!known_nxt)
			rdata_nxt = 32'h00000000;
	end

	// Answer registered in setup, so every access phase completes in one cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~known_nxt;
			prdata  <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h00000000;
		end
	end

	// ****************************************************************
	// Channel pin logic
	// ****************************************************************
	mfp_chan u_chan_a
	(
		.pclk                 (pclk),
		.presetn              (presetn),
		.modem_control_reg                  (mcr_a_r),
		.enhanced_feature_reg                  (efr_a_r),
		.interrupt_enable_reg                  (ier_a_r),
		.alternate_function_reg                  (afr_a_r),
		.divisor              (div_a_r),
		.tx_data              (tx_data_a),
		.rx_fifo_ready        (rx_fifo_ready_a),
		.rts_hold             (rts_hold_a),
		.serial_in            (serial_in_a),
		.cts_n                (cts_n_a),
		.dsr_n                (dsr_n_a),
		.cd_n                 (cd_n_a),
		.ri_n                 (ri_n_a),
		.serial_out_r         (serial_out_a),
		.rx_data_r            (rx_data_a),
		.rts_n_r              (rts_n_a),
		.dtr_n_r              (dtr_n_a),
		.multi_function_out_r (multi_function_out_a),
		.receive_ready_out_r  (receive_ready_out_a),
		.tx_allow_r           (tx_allow_a),
		.cts_flow_irq_r       (cts_flow_irq_a),
		.rts_flow_irq_r       (rts_flow_irq_a),
		.modem_stat_r         (modem_stat_a)
	);

	mfp_chan u_chan_b
	(
		.pclk                 (pclk),
		.presetn              (presetn),
		.modem_control_reg                  (mcr_b_r),
		.enhanced_feature_reg                  (efr_b_r),
		.interrupt_enable_reg                  (ier_b_r),
		.alternate_function_reg                  (afr_b_r),
		.divisor              (div_b_r),
		.tx_data              (tx_data_b),
		.rx_fifo_ready        (rx_fifo_ready_b),
		.rts_hold             (rts_hold_b),
		.serial_in            (serial_in_b),
		.cts_n                (cts_n_b),
		.dsr_n                (dsr_n_b),
		.cd_n                 (cd_n_b),
		.ri_n                 (ri_n_b),
		.serial_out_r         (serial_out_b),
		.rx_data_r            (rx_data_b),
		.rts_n_r              (rts_n_b),
		.dtr_n_r              (dtr_n_b),
		.multi_function_out_r (multi_function_out_b),
		.receive_ready_out_r  (receive_ready_out_b),
		.tx_allow_r           (tx_allow_b),
		.cts_flow_irq_r       (cts_flow_irq_b),
		.rts_flow_irq_r       (rts_flow_irq_b),
		.modem_stat_r         (modem_stat_b)
	);

endmodule

// ==== rtl/mfp_consts.vh ====
// Constants for the per-channel modem pin and multi-function output block.
// Assumes byte addresses on a 32-bit APB bus; only the low 6 bits decode.
`ifndef MFP_CONSTS_VH
`define MFP_CONSTS_VH

// ****************************************************************
// Register offsets within one channel window
// ****************************************************************
`define MFP_OFS_MCR       6'h00
`define MFP_OFS_EFR       6'h04
`define MFP_OFS_IER       6'h08
`define MFP_OFS_AFR       6'h0C
`define MFP_OFS_DIV       6'h10
`define MFP_OFS_STAT      6'h14
// Address bit that picks the channel window: 0 is channel B, 1 is channel A
`define MFP_CHANNEL_SELECT_BIT     5
`define MFP_ADDR_HI       7

// ****************************************************************
// Field positions
// ****************************************************************
`define MFP_MCR_DTR       0
`define MFP_MCR_RTS       1
`define MFP_MCR_OP2       3
`define MFP_EFR_AUTO_RTS  6
`define MFP_EFR_AUTO_CTS  7
`define MFP_IER_RTS       6
`define MFP_IER_CTS       7
`define MFP_AFR_SEL_LO    1
`define MFP_AFR_SEL_HI    2

// ****************************************************************
// Multi-function select codes
// ****************************************************************
`define MFP_SEL_OP2       2'h0
`define MFP_SEL_BAUD      2'h1
`define MFP_SEL_RXRDY     2'h2
`define MFP_SEL_SPARE     2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define MFP_RST_MCR       8'h08
`define MFP_RST_EFR       8'h00
`define MFP_RST_IER       8'h00
`define MFP_RST_AFR       8'h00
`define MFP_RST_DIV       16'h0010

`endif

// ==== rtl/mfp_chan.v ====
// One channel of serial and modem pin logic: synchronisers, 16x clock, pin drive.
// Assumes control words come from the register file on the same pclk.
`timescale 1ns/100ps
`include "mfp_consts.vh"

module mfp_chan
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire [7:0]  modem_control_reg,
	input  wire [7:0]  enhanced_feature_reg,
	input  wire [7:0]  interrupt_enable_reg,
	input  wire [7:0]  alternate_function_reg,
	input  wire [15:0] divisor,
	input  wire        tx_data,
	input  wire        rx_fifo_ready,
	input  wire        rts_hold,
	input  wire        serial_in,
	input  wire        cts_n,
	input  wire        dsr_n,
	input  wire        cd_n,
	input  wire        ri_n,
	output reg         serial_out_r,
	output reg         rx_data_r,
	output reg         rts_n_r,
	output reg         dtr_n_r,
	output reg         multi_function_out_r,
	output reg         receive_ready_out_r,
	output reg         tx_allow_r,
	output reg         cts_flow_irq_r,
	output reg         rts_flow_irq_r,
	output reg  [3:0]  modem_stat_r
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	reg  [4:0]  sync1_r;
	reg  [4:0]  sync2_r;
	reg  [15:0] baud_cnt_r;
	reg         baud_r;
	wire [15:0] baud_cnt_nxt;
	wire [15:0] baud_half;
	wire [1:0]  mf_sel;
	wire        auto_cts;
	wire        auto_rts;

	// Idle level is high, so reset loads one and ignores the line meanwhile
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= 5'h1F;
			sync2_r <= 5'h1F;
		end
		else
		begin
			sync1_r <= {ri_n, cd_n, dsr_n, cts_n, serial_in};
			sync2_r <= sync1_r;
		end
	end

	// ****************************************************************
	// 16x baud clock
	// ****************************************************************
	// A divisor below two holds the clock high; no sub-pclk rates exist
	assign baud_cnt_nxt = (baud_cnt_r + 16'h0001 >= divisor) ? 16'h0000
		: baud_cnt_r + 16'h0001;
	assign baud_half    = {1'b0, divisor[15:1]};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			baud_cnt_r <= 16'h0000;
			baud_r     <= 1'b1;
		end
		else
		begin
			baud_cnt_r <= baud_cnt_nxt;
			baud_r     <= (divisor < 16'h0002) | (baud_cnt_nxt < divisor - baud_half);
		end
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	assign mf_sel   = alternate_function_reg[`MFP_AFR_SEL_HI:`MFP_AFR_SEL_LO];
	assign auto_cts = enhanced_feature_reg[`MFP_EFR_AUTO_CTS];
	assign auto_rts = enhanced_feature_reg[`MFP_EFR_AUTO_RTS];

	// DSR, CD and RI only feed the readable status word; CTS also gates tx_allow_r and the flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_out_r         <= 1'b1;
			rx_data_r            <= 1'b1;
			rts_n_r              <= 1'b1;
			dtr_n_r              <= 1'b1;
			multi_function_out_r <= 1'b0;
			receive_ready_out_r  <= 1'b1;
			tx_allow_r           <= 1'b0;
			cts_flow_irq_r       <= 1'b0;
			rts_flow_irq_r       <= 1'b0;
			modem_stat_r         <= 4'h0;
		end
		else
		begin
			serial_out_r        <= tx_data;
			rx_data_r           <= sync2_r[0];
			dtr_n_r             <= ~modem_control_reg[`MFP_MCR_DTR];
			// Auto RTS only withdraws a request software has already made
			rts_n_r             <= ~modem_control_reg[`MFP_MCR_RTS] | (auto_rts & rts_hold);
			receive_ready_out_r <= ~rx_fifo_ready;
			tx_allow_r          <= ~auto_cts | ~sync2_r[1];
			cts_flow_irq_r      <= auto_cts & interrupt_enable_reg[`MFP_IER_CTS] & sync2_r[1];
			rts_flow_irq_r      <= auto_rts & interrupt_enable_reg[`MFP_IER_RTS] & rts_hold;
			modem_stat_r        <= ~sync2_r[4:1];
			case (mf_sel)
				`MFP_SEL_BAUD:  multi_function_out_r <= baud_r;
				`MFP_SEL_RXRDY: multi_function_out_r <= ~rx_fifo_ready;
				default:        multi_function_out_r <= ~modem_control_reg[`MFP_MCR_OP2];
			endcase
		end
	end

endmodule

// ==== sim/mfp_peer.sv ====
// Modem or serial peer facing both channels: line and modem input levels.
// Assumes the bench calls set right after a rising pclk edge.
`timescale 1ns/100ps
module mfp_peer
(
	output logic serial_in_a,
	output logic cts_n_a,
	output logic dsr_n_a,
	output logic cd_n_a,
	output logic ri_n_a,
	output logic serial_in_b,
	output logic cts_n_b,
	output logic dsr_n_b,
	output logic cd_n_b,
	output logic ri_n_b
);
	// Idle at mark, modem lines deasserted, until told otherwise
	initial
	begin
		{serial_in_a, cts_n_a, dsr_n_a, cd_n_a, ri_n_a} = 5'h1F;
		{serial_in_b, cts_n_b, dsr_n_b, cd_n_b, ri_n_b} = 5'h1F;
	end
	// Order per channel: line, clear, set ready, carrier, ring
	task set(input logic [4:0] a, input logic [4:0] b);
		{serial_in_a, cts_n_a, dsr_n_a, cd_n_a, ri_n_a} <= a;
		{serial_in_b, cts_n_b, dsr_n_b, cd_n_b, ri_n_b} <= b;
	endtask
endmodule

// ==== sim/mfp_chk.sv ====
// Checker of the modem pin block: bus answer, pin drive and select paths.
// Assumes it is bound to mfp_top; tracks channel A words from bus writes.
`timescale 1ns/100ps
module mfp_chk
(
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        tx_data_a,
	input wire        tx_data_b,
	input wire        rx_fifo_ready_a,
	input wire        rts_hold_a,
	input wire        cts_n_a,
	input wire        serial_out_a,
	input wire        serial_out_b,
	input wire        rts_n_a,
	input wire        dtr_n_a,
	input wire        multi_function_out_a,
	input wire        receive_ready_out_a,
	input wire        tx_allow_a
);
	// ****************************************************************
	// Shadow words; the age count hides synchroniser start-up
	// ****************************************************************
	logic [7:0] mcr_r, efr_r, afr_r;
	logic [2:0] age_r;
	wire        wr = psel && penable && pwrite && pready && !pslverr;
	wire        up = (age_r == 3'h4);
	// Shadows update on the accepting edge, as the registers do
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mcr_r <= 8'h08;
			efr_r <= 8'h00;
			afr_r <= 8'h00;
			age_r <= 3'h0;
		end
		else
		begin
			if (!up)
				age_r <= age_r + 3'h1;
			if (wr && paddr == 32'h20)
				mcr_r <= pwdata[7:0];
			if (wr && paddr == 32'h24)
				efr_r <= pwdata[7:0];
			if (wr && paddr == 32'h2C)
				afr_r <= pwdata[7:0];
		end
	end
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_access;
		psel && penable && pready;
	endsequence
	chk_bus_answer: assert property (apb_setup |=> apb_access)
		else $error("no answer one cycle after setup");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("refused access with data or without ready");
	chk_idle_quiet: assert property (!(psel && penable) |-> !pready && prdata == 32'h0)
		else $error("bus answer outside access");
	chk_rx_ready: assert property (up |-> receive_ready_out_a == !$past(rx_fifo_ready_a))
		else $error("receive ready pin wrong");
	chk_tx_follow: assert property (up |-> serial_out_a == $past(tx_data_a)
		&& serial_out_b == $past(tx_data_b))
		else $error("transmit pin wrong");
	chk_dtr_rts: assert property (up |-> dtr_n_a == !$past(mcr_r[1'b0]) && rts_n_a ==
		(!$past(mcr_r[1]) || ($past(efr_r[6]) && $past(rts_hold_a))))
		else $error("modem output pins wrong");
	chk_cts_gate: assert property (up |-> tx_allow_a ==
		(!$past(efr_r[7]) || !$past(cts_n_a, 3)))
		else $error("clear to send gate wrong");
	chk_mf_user: assert property (up && ($past(afr_r[2:1]) == 2'h0
		|| $past(afr_r[2:1]) == 2'h3) |-> multi_function_out_a == !$past(mcr_r[3]))
		else $error("multi-function user output wrong");
	chk_mf_rxrdy: assert property (up && $past(afr_r[2:1]) == 2'h2
		|-> multi_function_out_a == receive_ready_out_a)
		else $error("multi-function receive ready wrong");
endmodule
bind mfp_top mfp_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .tx_data_a, .tx_data_b, .rx_fifo_ready_a, .rts_hold_a,
	.cts_n_a, .serial_out_a, .serial_out_b, .rts_n_a, .dtr_n_a, .multi_function_out_a,
	.receive_ready_out_a, .tx_allow_a);

// ==== sim/mfp_tb_top.sv ====
// Bench for mfp_top: APB host tasks, peer model on the modem pins.
// Assumes channel A at byte 0x20, channel B at 0x00; stimulus at rising edges.
`timescale 1ns/100ps
module mfp_tb_top;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, q;
	logic        tx_data_a, tx_data_b, rx_fifo_ready_a, rx_fifo_ready_b;
	logic        rts_hold_a, rts_hold_b, prev;
	int          errors, tests_run, highs, rises;
	wire  [31:0] prdata;
	wire         pready, pslverr, serial_in_a, cts_n_a, dsr_n_a, cd_n_a, ri_n_a;
	wire         serial_in_b, cts_n_b, dsr_n_b, cd_n_b, ri_n_b, serial_out_a, serial_out_b;
	wire         rx_data_a, rx_data_b, rts_n_a, rts_n_b, dtr_n_a, dtr_n_b;
	wire         multi_function_out_a, multi_function_out_b, receive_ready_out_a;
	wire         receive_ready_out_b, tx_allow_a, tx_allow_b;
	wire         cts_flow_irq_a, cts_flow_irq_b, rts_flow_irq_a, rts_flow_irq_b;
	mfp_peer peer (.serial_in_a, .cts_n_a, .dsr_n_a, .cd_n_a, .ri_n_a,
		.serial_in_b, .cts_n_b, .dsr_n_b, .cd_n_b, .ri_n_b);
	mfp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tx_data_a, .tx_data_b, .rx_fifo_ready_a, .rx_fifo_ready_b,
		.rts_hold_a, .rts_hold_b, .serial_in_a, .serial_in_b, .cts_n_a, .cts_n_b,
		.dsr_n_a, .dsr_n_b, .cd_n_a, .cd_n_b, .ri_n_a, .ri_n_b, .serial_out_a,
		.serial_out_b, .rx_data_a, .rx_data_b, .rts_n_a, .rts_n_b, .dtr_n_a, .dtr_n_b,
		.multi_function_out_a, .multi_function_out_b, .receive_ready_out_a,
		.receive_ready_out_b, .tx_allow_a, .tx_allow_b, .cts_flow_irq_a, .cts_flow_irq_b,
		.rts_flow_irq_a, .rts_flow_irq_b);
	// ****************************************************************
	// Clock, tasks
	// ****************************************************************
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task results;
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One transfer; waits on pready, never on a fixed count
	task apb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic e;
		apb(a, 1'b1, d, e);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
		logic e;
		apb(a, 1'b0, 32'h0, e);
		chk("prdata", x, q);
		chk("pslverr", xe, e);
	endtask
	// Watchdog well beyond the roughly 160 cycles the sequence needs
	initial
	begin
		wt(5000);
		errors++;
		results;
	end
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = 68'h0;
		{tx_data_a, tx_data_b, rx_fifo_ready_a, rx_fifo_ready_b, rts_hold_a, rts_hold_b} = 6'h0;
		{errors, tests_run} = 0;
		wt(2);
		chk("serial_out_a", 1, serial_out_a);
		presetn <= 1'b1;
		rd(32'h20, 32'h08, 0);
		rd(32'h2C, 32'h00, 0);
		chk("mf_a", 0, multi_function_out_a);
		chk("dtr_n_a", 1, dtr_n_a);
		rd(32'h18, 0, 1);
		rd(32'h21, 0, 1);
		wr(32'h20, 32'h03);
		wt(2);
		chk("dtr_rts_a", 2'b00, {dtr_n_a, rts_n_a});
		rd(32'h00, 32'h08, 0);
		chk("dtr_n_b", 1, dtr_n_b);
		wr(32'h00, 32'h02);
		wr(32'h04, 32'hC0);
		wr(32'h08, 32'hC0);
		wt(2);
		chk("pins_b", 3'b101, {dtr_n_b, rts_n_b, multi_function_out_b});
		wr(32'h24, 32'hC0);
		wr(32'h28, 32'hC0);
		{rts_hold_a, rts_hold_b} <= 2'b11;
		wt(2);
		chk("rts_a", 2'b11, {rts_n_a, rts_flow_irq_a});
		chk("rts_b", 2'b11, {rts_n_b, rts_flow_irq_b});
		{rts_hold_a, rts_hold_b} <= 2'b00;
		peer.set(5'b11000, 5'b00000);
		wt(5);
		chk("cts_a", 2'b01, {tx_allow_a, cts_flow_irq_a});
		chk("cts_b", 3'b100, {tx_allow_b, cts_flow_irq_b, rx_data_b});
		rd(32'h34, 32'h0E, 0);
		peer.set(5'b00111, 5'b11111);
		wt(5);
		chk("cts_a", 2'b10, {tx_allow_a, cts_flow_irq_a});
		chk("cts_b", 3'b011, {tx_allow_b, cts_flow_irq_b, rx_data_b});
		chk("rx_data_a", 0, rx_data_a);
		peer.set(5'b10111, 5'b11111);
		rx_fifo_ready_a <= 1'b1;
		rx_fifo_ready_b <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			wr(32'h2C, s << 1);
			wt(2);
			if (s != 1)
				chk("mf_a", s != 2, multi_function_out_a);
		end
		chk("rdy_a_b", 2'b00, {receive_ready_out_a, receive_ready_out_b});
		wr(32'h0C, 32'h4);
		wt(2);
		chk("mf_b", 0, multi_function_out_b);
		wr(32'h30, 32'h6);
		wr(32'h2C, 32'h2);
		wt(40);
		{highs, rises, prev} = {32'h0, 32'h0, multi_function_out_a};
		repeat (24)
		begin
			@(posedge pclk);
			rises += (multi_function_out_a && !prev);
			highs += multi_function_out_a;
			prev = multi_function_out_a;
		end
		chk("baud_high", 24 / 6 * (6 - 6 / 2), highs);
		chk("baud_rise", 24 / 6, rises);
		{tx_data_a, tx_data_b} <= 2'b10;
		wt(2);
		chk("serial_out", 2'b10, {serial_out_a, serial_out_b});
		tx_data_a <= 1'b0;
		presetn <= 1'b0;
		wt(2);
		chk("rst_pins", 3'b110, {serial_out_a, serial_out_b, multi_function_out_a});
		presetn <= 1'b1;
		rd(32'h20, 32'h08, 0);
		results;
	end
endmodule
